// ===== rtl/mdc_pkg.sv
package mdc_pkg;
	// Frame geometry
	localparam int unsigned FRAME_BITS = 24;
	localparam logic [4:0] FRAME_LEN = 5'h18;
	localparam logic [4:0] ADDR_LEN = 5'h08;
	// Frame operation codes, top two bits of the first byte
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_READ = 2'h1;
	localparam logic [1:0] OP_READ_CLR = 2'h2;
	localparam logic [1:0] OP_ROM = 2'h3;
	// Writable space, plus read-only read-clear status words at 11h-14h
	localparam logic [5:0] A_BRIDGE_WD = 6'h01;
	localparam logic [5:0] A_DRIVER_EC = 6'h02;
	localparam logic [5:0] A_RECOVERY_LIN = 6'h03;
	localparam logic [5:0] A_PWM_MON = 6'h04;
	localparam logic [5:0] A_OVERCURRENT = 6'h11;
	localparam logic [5:0] A_OPEN_LOAD = 6'h12;
	localparam logic [5:0] A_SUPPLY_WD_EC = 6'h13;
	localparam logic [5:0] A_LIN_THERMAL = 6'h14;
	localparam logic [5:0] A_DEVICE_CFG = 6'h3f;
	// Read-only space
	localparam logic [5:0] A_IDENTITY = 6'h00;
	localparam logic [5:0] A_VERSION = 6'h01;
	localparam logic [5:0] A_PRODUCT_A = 6'h02;
	localparam logic [5:0] A_PRODUCT_B = 6'h03;
	localparam logic [5:0] A_FRAME_FMT = 6'h3e;
	// Read-only contents; identity words are arbitrary neutral values
	localparam logic [15:0] IDENTITY_VAL = 16'h0a5a;
	localparam logic [15:0] VERSION_VAL = 16'h0001;
	localparam logic [15:0] PRODUCT_A_VAL = 16'h0b01;
	localparam logic [15:0] PRODUCT_B_VAL = 16'h0b02;
	localparam logic [15:0] FRAME_FMT_VAL = 16'h4200;
	// Reset values
	localparam logic [15:0] BRIDGE_WD_RST = 16'h0020;
	localparam logic [15:0] DRIVER_EC_RST = 16'h0000;
	localparam logic [15:0] RECOVERY_LIN_RST = 16'h0040;
	localparam logic [15:0] PWM_MON_RST = 16'h0000;
	localparam logic [15:0] DEVICE_CFG_RST = 16'h0000;
	// Writable masks; reserved and one-shot bits read zero
	localparam logic [15:0] BRIDGE_WD_MASK = 16'hfff9;
	localparam logic [15:0] TOP_RSVD_MASK = 16'h7fff;
	// Bridge and watchdog control field positions
	localparam int unsigned F_BRIDGE_LO = 6;
	localparam int unsigned F_IRQ_SHARE = 5;
	localparam int unsigned F_RST_SEL = 4;
	localparam int unsigned F_LOAD_CMP = 3;
	localparam int unsigned F_STBY_KIND = 2;
	localparam int unsigned F_STBY_CMD = 1;
	localparam int unsigned F_KICK = 0;
	// Driver and glass control field positions
	localparam int unsigned F_GLASS_EN = 0;
	localparam int unsigned F_GLASS_REF = 1;
	localparam int unsigned F_GLASS_ND = 7;
	localparam int unsigned F_PWM_EN_LO = 0;
	localparam int unsigned NUM_BRIDGES = 5;
	localparam int unsigned NUM_STATUS = 4;

	// Serial pin bundle
	typedef struct packed {
		logic csn;
		logic sck;
		logic sdi;
	} mdc_spi_in_type;

	// Whole state of the bank
	typedef struct packed {
		logic csn_q;
		logic sck_q;
		logic [4:0] cnt;
		logic [23:0] rx;
		logic [7:0] head;
		logic [15:0] rdata;
		logic sdo;
		logic sdo_en;
		logic [15:0] bridge_wd;
		logic [15:0] driver_ec;
		logic [15:0] recovery_lin;
		logic [15:0] pwm_mon;
		logic [15:0] device_cfg;
		logic [3:0][15:0] status;
		logic [4:0] hs_on;
		logic [4:0] ls_on;
		logic kick;
		logic stby_go;
		logic stby_kind;
		logic wd_off;
		logic rxd_n;
	} mdc_state_type;
endpackage

// ===== rtl/mdc_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - Four control registers at 01h to 04h
// - Four read-clear status registers at 11h-14h
// - Read-only 3Eh holds frame format word
// - Set enable bit switches its driver on
// - PWM-enabled driver on only while PWM high
// - Both sides set gives high impedance
// - Bit 5 shares receive pin as interrupt
// - Bit selects undervoltage reset threshold level
// - Bit 3 sets watchdog off in regulator standby
// - Standby kind bit one-shot, reads zero
// - Standby command bit one-shot, reads zero
// - Second control register resets all zero
module mdc_regs (
	input wire logic clk, // 250 MHz logic clock
	input wire logic srst, // Synchronous reset, high
	input wire mdc_pkg::mdc_spi_in_type spi, // Chip select, clock, data in
	output logic spi_sdo, // Serial data out
	output logic spi_sdo_en, // Data out driven while selected
	input wire logic [3:0][15:0] status_set, // Diagnostic event pulses
	input wire logic pwm1, // PWM1 input
	input wire logic lin_rxd, // Receive data from transceiver
	input wire logic irq_request, // Interrupt condition, high
	input wire logic in_reg_standby, // Regulator-on standby active
	input wire logic icc_below_cmp, // Load current under threshold
	output logic [4:0] bridge_high_on, // High-side gates
	output logic [4:0] bridge_low_on, // Low-side gates
	output logic irq_out_n, // Shared receive/interrupt pin
	output logic reset_threshold_sel, // 0: 4.7 V, 1: 3.5 V
	output logic watchdog_off, // Watchdog held off
	output logic watchdog_kick, // Trigger pulse
	output logic standby_command, // Standby entry pulse
	output logic standby_kind_sel, // 0 battery, 1 regulator
	output logic [15:0] driver_ec_ctrl, // Second control word
	output logic [15:0] recovery_lin_ctrl, // Third control word
	output logic [15:0] pwm_monitor_ctrl // Fourth control word
);
	import mdc_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Decoding for the read path (read_word) and the clear path (status_index)
	function automatic logic [15:0] read_word(input mdc_state_type s,
		input logic [1:0] op, input logic [5:0] a);
		logic [15:0] w;
		w = 16'h0000;
		if (op == OP_ROM) begin
			unique case (a)
				A_IDENTITY: w = IDENTITY_VAL;
				A_VERSION: w = VERSION_VAL;
				A_PRODUCT_A: w = PRODUCT_A_VAL;
				A_PRODUCT_B: w = PRODUCT_B_VAL;
				A_FRAME_FMT: w = FRAME_FMT_VAL;
				default: w = 16'h0000;
			endcase
		end else begin
			unique case (a)
				A_BRIDGE_WD: w = s.bridge_wd;
				A_DRIVER_EC: w = s.driver_ec;
				A_RECOVERY_LIN: w = s.recovery_lin;
				A_PWM_MON: w = s.pwm_mon;
				A_OVERCURRENT: w = s.status[0];
				A_OPEN_LOAD: w = s.status[1];
				A_SUPPLY_WD_EC: w = s.status[2];
				A_LIN_THERMAL: w = s.status[3];
				A_DEVICE_CFG: w = s.device_cfg;
				default: w = 16'h0000;
			endcase
		end
		return w;
	endfunction

	// Status word index for a status address, or 4 for none
	function automatic logic [2:0] status_index(input logic [5:0] a);
		logic [2:0] i;
		i = 3'h4;
		if (a >= A_OVERCURRENT && a <= A_LIN_THERMAL) begin
			i = 3'(a - A_OVERCURRENT);
		end
		return i;
	endfunction

	////////////////////////////////////////////////////////////////////
	// State
	mdc_state_type q; // Registered state
	mdc_state_type d; // Next state
	logic sck_rise; // Serial clock rising edge
	logic sck_fall; // Serial clock falling edge
	logic frame_end; // Chip select released
	logic frame_ok; // Exactly one full frame seen
	logic [1:0] f_op; // Operation of finished frame
	logic [5:0] f_addr; // Address of finished frame
	logic [15:0] f_data; // Data of finished frame
	logic [2:0] clr_idx; // Status word to clear
	logic [3:0][15:0] clr_mask; // Bits to clear

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		d = q;
		sck_rise = !spi.csn && !q.sck_q && spi.sck;
		sck_fall = !spi.csn && q.sck_q && !spi.sck;
		frame_end = !q.csn_q && spi.csn;
		// Short or long frames are dropped whole
		frame_ok = frame_end && (q.cnt == FRAME_LEN);
		f_op = q.rx[23:22];
		f_addr = q.rx[21:16];
		f_data = q.rx[15:0];
		clr_idx = status_index(f_addr);
		clr_mask = '0;
		d.csn_q = spi.csn;
		d.sck_q = spi.sck;
		d.kick = 1'b0;
		d.stby_go = 1'b0;
		// Start of frame: header flags any pending diagnosis
		if (q.csn_q && !spi.csn) begin
			d.cnt = 5'h00;
			d.head = {(|q.status), 7'h00};
			d.sdo = |q.status;
			d.sdo_en = 1'b1;
		end
		if (spi.csn) begin
			d.sdo_en = 1'b0;
		end
		// Shift in on rising edge; saturate to flag long frames
		if (sck_rise) begin
			d.rx = {q.rx[22:0], spi.sdi};
			if (q.cnt != 5'h1f) begin
				d.cnt = q.cnt + 5'h01;
			end
			// Address complete: capture read word for the data phase
			if (q.cnt + 5'h01 == ADDR_LEN) begin
				d.rdata = read_word(q, q.rx[6:5], {q.rx[4:0], spi.sdi});
			end
		end
		// Shift out on falling edge
		if (sck_fall) begin
			if (q.cnt < ADDR_LEN) begin
				d.sdo = q.head[3'(7 - q.cnt)];
			end else if (q.cnt < FRAME_LEN) begin
				d.sdo = q.rdata[4'(23 - q.cnt)];
			end else begin
				d.sdo = 1'b0;
			end
		end
		// Register writes at the end of a valid frame
		if (frame_ok && f_op == OP_WRITE) begin
			unique case (f_addr)
				A_BRIDGE_WD: begin
					// One-shot bits never stored
					d.bridge_wd = f_data & BRIDGE_WD_MASK;
					d.kick = f_data[F_KICK] != q.bridge_wd[F_KICK];
					d.stby_go = f_data[F_STBY_CMD];
					if (f_data[F_STBY_CMD]) begin
						d.stby_kind = f_data[F_STBY_KIND];
					end
				end
				A_DRIVER_EC: d.driver_ec = f_data & TOP_RSVD_MASK;
				A_RECOVERY_LIN: d.recovery_lin = f_data & TOP_RSVD_MASK;
				A_PWM_MON: d.pwm_mon = f_data;
				A_DEVICE_CFG: begin
					d.device_cfg = f_data;
					// Either trigger bit may be used by the host
					d.kick = f_data[F_KICK] != q.device_cfg[F_KICK];
				end
				default: d.kick = 1'b0;
			endcase
		end
		// Read-clear; a new event in the same cycle survives
		if (frame_ok && f_op == OP_READ_CLR && clr_idx != 3'h4) begin
			clr_mask[2'(clr_idx)] = 16'hffff;
		end
		d.status = (q.status & ~clr_mask) | status_set;
		// Half-bridge gates; registered to keep outputs glitch free
		for (int i = 0; i < NUM_BRIDGES; i++) begin
			logic hs;
			logic ls;
			logic gate;
			hs = q.bridge_wd[F_BRIDGE_LO + 2 * i + 1];
			ls = q.bridge_wd[F_BRIDGE_LO + 2 * i];
			gate = !q.recovery_lin[F_PWM_EN_LO + i] || pwm1;
			// Both requested: neither conducts, output floats
			d.hs_on[i] = hs && !ls && gate;
			d.ls_on[i] = ls && !hs && gate;
		end
		// Pin sharing adds active-low interrupt onto receive data
		d.rxd_n = q.bridge_wd[F_IRQ_SHARE] ?
			(lin_rxd && !irq_request) : lin_rxd;
		// Bit 3 or load current under threshold holds watchdog off in regulator standby
		d.wd_off = in_reg_standby &&
			(q.bridge_wd[F_LOAD_CMP] || icc_below_cmp);
		if (srst) begin
			d = '0;
			d.csn_q = 1'b1;
			d.rxd_n = 1'b1;
			d.bridge_wd = BRIDGE_WD_RST;
			d.driver_ec = DRIVER_EC_RST;
			d.recovery_lin = RECOVERY_LIN_RST;
			d.pwm_mon = PWM_MON_RST;
			d.device_cfg = DEVICE_CFG_RST;
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk) begin
		q <= d;
	end

	////////////////////////////////////////////////////////////////////
	// Outputs, all from flops
	assign spi_sdo = q.sdo;
	assign spi_sdo_en = q.sdo_en;
	assign bridge_high_on = q.hs_on;
	assign bridge_low_on = q.ls_on;
	assign irq_out_n = q.rxd_n;
	assign reset_threshold_sel = q.bridge_wd[F_RST_SEL];
	assign watchdog_off = q.wd_off;
	assign watchdog_kick = q.kick;
	assign standby_command = q.stby_go;
	assign standby_kind_sel = q.stby_kind;
	assign driver_ec_ctrl = q.driver_ec;
	assign recovery_lin_ctrl = q.recovery_lin;
	assign pwm_monitor_ctrl = q.pwm_mon;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// A broken frame must leave every writable word untouched
	bad_frame_a: assert property (
		frame_end && q.cnt != FRAME_LEN |=> $stable(q.bridge_wd) &&
		$stable(q.driver_ec) && $stable(q.recovery_lin) &&
		$stable(q.pwm_mon) && $stable(q.device_cfg))
		else $error("short frame changed a register");
	// One-shot standby bits are never kept in the word
	oneshot_zero_a: assert property (
		q.bridge_wd[F_STBY_CMD] == 1'b0 &&
		q.bridge_wd[F_STBY_KIND] == 1'b0)
		else $error("one-shot bit stored");
	// Standby command is a single-cycle pulse after the frame
	stby_pulse_a: assert property (
		frame_ok && f_op == OP_WRITE && f_addr == A_BRIDGE_WD &&
		f_data[F_STBY_CMD] |=> standby_command ##1 !standby_command)
		else $error("standby pulse wrong");
	// Standby kind is taken from the same write as the command
	stby_kind_a: assert property (
		frame_ok && f_op == OP_WRITE && f_addr == A_BRIDGE_WD &&
		f_data[F_STBY_CMD] |=>
		standby_kind_sel == $past(f_data[F_STBY_KIND]))
		else $error("standby kind not taken");
	// Both sides requested on bridge 1: neither gate may conduct
	conflict_hiz_a: assert property (
		q.bridge_wd[F_BRIDGE_LO + 1] && q.bridge_wd[F_BRIDGE_LO] |=>
		!bridge_high_on[0] && !bridge_low_on[0])
		else $error("both sides of bridge on");
	// PWM-gated bridge 1 stays off while the PWM input is low
	pwm_gate_a: assert property (
		q.recovery_lin[F_PWM_EN_LO] && !pwm1 |=>
		!bridge_high_on[0] && !bridge_low_on[0])
		else $error("driver on while pwm low");
	// Ungated single-side request on bridge 5 turns its gate on
	drive_on_a: assert property (
		q.bridge_wd[F_BRIDGE_LO + 9] && !q.bridge_wd[F_BRIDGE_LO + 8] &&
		!q.recovery_lin[F_PWM_EN_LO + 4] |=> bridge_high_on[4])
		else $error("enabled driver stayed off");
	// Without sharing the pin carries receive data only
	irq_share_a: assert property (
		!q.bridge_wd[F_IRQ_SHARE] |=> irq_out_n == $past(lin_rxd))
		else $error("interrupt leaked onto receive pin");
	// Read-clear keeps only what was set in the clearing cycle
	clr_keep_a: assert property (
		frame_ok && f_op == OP_READ_CLR && f_addr == A_OVERCURRENT |=>
		q.status[0] == $past(status_set[0]))
		else $error("status clear wrong");
	// Compare bit set: watchdog held off in regulator standby
	wd_cmp_a: assert property (
		in_reg_standby && q.bridge_wd[F_LOAD_CMP] |=> watchdog_off)
		else $error("watchdog not held off");
	// Reset leaves the first two registers at their reset words
	cr2_reset_a: assert property (
		$past(srst) |-> q.driver_ec == 16'h0000 &&
		q.bridge_wd == BRIDGE_WD_RST)
		else $error("reset value wrong");
	// A changed trigger bit in the configuration word kicks too
	cfg_kick_a: assert property (
		frame_ok && f_op == OP_WRITE && f_addr == A_DEVICE_CFG &&
		f_data[F_KICK] != q.device_cfg[F_KICK] |=> watchdog_kick)
		else $error("configuration trigger lost");
	// A kick never stretches over two cycles
	kick_pulse_a: assert property (
		watchdog_kick |=> !watchdog_kick)
		else $error("kick longer than a cycle");
	// Reserved top bits of the second and third words stay clear
	rsvd_zero_a: assert property (
		(q.driver_ec & ~TOP_RSVD_MASK) == 16'h0000 &&
		(q.recovery_lin & ~TOP_RSVD_MASK) == 16'h0000)
		else $error("reserved bit stored");
endmodule
`default_nettype wire

// ===== tb/mdc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side of the serial frame: mode 0, sck idle low
module mdc_host_model (
	input wire logic clk, // Logic clock
	input wire logic sdo, // Data from the bank
	output var mdc_pkg::mdc_spi_in_type spi // Select, clock, data
);
	import mdc_pkg::*;
	initial spi = 3'h4; // Deselected, clock low
	////////////////////////////////////////
	// Wait n edges, then step just past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One frame; n other than 24 makes a broken frame on purpose
	task automatic frame(input logic [1:0] op, input logic [5:0] a,
		input logic [15:0] d, input int n, output logic [15:0] r);
		logic [23:0] w;
		w = {op, a, d};
		r = 16'h0000;
		spi.csn = 1'b0;
		cyc(2);
		for (int i = 0; i < n; i++) begin
			spi.sdi = w[23 - (i % 24)];
			cyc(3); // Slow edges: the bank samples sck with clk
			r = {r[14:0], sdo};
			spi.sck = 1'b1;
			cyc(2);
			spi.sck = 1'b0;
		end
		cyc(3);
		spi.csn = 1'b1;
		spi.sdi = ~spi.sdi; // Released line shows no stale bit
		cyc(4);
	endtask
endmodule
`default_nettype wire

// ===== tb/mdc_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mdc_regs_tb;
	import mdc_pkg::*;
	logic clk, srst, sdo, sdo_en, pwm1, lin_rxd, irq_req, in_stby, icc_low;
	logic irq_out_n, rst_sel, wd_off, kick, stby_go, stby_kind;
	logic [3:0][15:0] status_set;
	logic [4:0] hi_on, lo_on;
	logic [15:0] rd, ec_ctrl, rl_ctrl, pm_ctrl;
	mdc_spi_in_type spi;
	int errors, compares, kicks, gos, ens, k;
	mdc_host_model u_mdc_host_model (.clk(clk), .sdo(sdo), .spi(spi));
	mdc_regs u_mdc_regs (.clk(clk), .srst(srst), .spi(spi),
		.spi_sdo(sdo), .spi_sdo_en(sdo_en), .status_set(status_set),
		.pwm1(pwm1), .lin_rxd(lin_rxd), .irq_request(irq_req),
		.in_reg_standby(in_stby), .icc_below_cmp(icc_low),
		.bridge_high_on(hi_on), .bridge_low_on(lo_on),
		.irq_out_n(irq_out_n), .reset_threshold_sel(rst_sel),
		.watchdog_off(wd_off), .watchdog_kick(kick),
		.standby_command(stby_go), .standby_kind_sel(stby_kind),
		.driver_ec_ctrl(ec_ctrl), .recovery_lin_ctrl(rl_ctrl),
		.pwm_monitor_ctrl(pm_ctrl));
	////////////////////////////////////////
	// Clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Pulses are one cycle wide, so count them at every edge
	always @(posedge clk) begin
		if (kick === 1'b1) kicks++;
		if (stby_go === 1'b1) gos++;
		if (sdo_en === 1'b1) ens++;
	end
	////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		u_mdc_host_model.frame(OP_WRITE, a, d, 24, rd);
	endtask
	task automatic rdw(input logic [1:0] op, input logic [5:0] a,
		input logic [15:0] e);
		u_mdc_host_model.frame(op, a, 16'h0000, 24, rd);
		chk(rd, e);
	endtask
	////////////////////////////////////////
	// Reset words and read-only frame word
	task automatic t_reset;
		chk(rst_sel, 16'h0000);
		rdw(OP_READ, 6'h01, 16'h0020);
		rdw(OP_READ, 6'h02, 16'h0000);
		rdw(OP_READ, 6'h03, 16'h0040);
		rdw(OP_ROM, 6'h3e, 16'h4200);
		$display("t_reset done");
	endtask
	// Gates: single side, conflict, PWM gating
	task automatic t_bridge;
		wr(6'h01, 16'h8000);
		chk(hi_on, 16'h0010);
		wr(6'h01, 16'h0080);
		chk(hi_on, 16'h0001);
		wr(6'h01, 16'h4000);
		chk(lo_on, 16'h0010);
		wr(6'h01, 16'h00c0);
		chk({hi_on, lo_on}, 16'h0000);
		wr(6'h03, 16'h0001);
		chk(rl_ctrl, 16'h0001);
		wr(6'h01, 16'h0080);
		chk(hi_on, 16'h0000);
		pwm1 = 1'b1;
		u_mdc_host_model.cyc(3);
		chk(hi_on, 16'h0001);
		pwm1 = 1'b0;
		$display("t_bridge done");
	endtask
	// Shared pin, threshold, one-shot standby bits
	task automatic t_ctrl;
		irq_req = 1'b1;
		wr(6'h01, 16'h0020);
		chk(irq_out_n, 16'h0000);
		wr(6'h01, 16'h0010);
		chk(irq_out_n, 16'h0001);
		chk(rst_sel, 16'h0001);
		k = gos;
		wr(6'h01, 16'h0006);
		chk(16'(gos - k), 16'h0001);
		chk(stby_kind, 16'h0001);
		rdw(OP_READ, 6'h01, 16'h0000);
		$display("t_ctrl done");
	endtask
	// Watchdog hold-off and both trigger bits
	task automatic t_wd;
		in_stby = 1'b1;
		wr(6'h01, 16'h0000);
		chk(wd_off, 16'h0000);
		icc_low = 1'b1;
		u_mdc_host_model.cyc(3);
		chk(wd_off, 16'h0001);
		icc_low = 1'b0;
		wr(6'h01, 16'h0008);
		chk(wd_off, 16'h0001);
		k = kicks;
		wr(6'h01, 16'h0009);
		wr(6'h3f, 16'h0001);
		wr(6'h3f, 16'h0001);
		chk(16'(kicks - k), 16'h0002);
		rdw(OP_READ, 6'h3f, 16'h0001);
		$display("t_wd done");
	endtask
	// Sticky status, refused write, read-clear
	task automatic t_status;
		status_set[1] = 16'h0005;
		status_set[0] = 16'h0003;
		u_mdc_host_model.cyc(1);
		status_set = '0;
		wr(6'h12, 16'h0000);
		rdw(OP_READ, 6'h12, 16'h0005);
		rdw(OP_READ_CLR, 6'h12, 16'h0005);
		rdw(OP_READ, 6'h12, 16'h0000);
		rdw(OP_READ_CLR, 6'h11, 16'h0003);
		rdw(OP_READ, 6'h11, 16'h0000);
		$display("t_status done");
	endtask
	// Reserved bit, bad bit counts ignored
	task automatic t_frame;
		wr(6'h02, 16'hffff);
		chk(ec_ctrl, 16'h7fff);
		u_mdc_host_model.frame(OP_WRITE, 6'h02, 16'h1234, 23, rd);
		u_mdc_host_model.frame(OP_WRITE, 6'h02, 16'h1234, 25, rd);
		rdw(OP_READ, 6'h02, 16'h7fff);
		k = ens;
		wr(6'h04, 16'h00a5);
		chk(16'(ens - k), 16'h007d);
		chk(pm_ctrl, 16'h00a5);
		rdw(OP_READ, 6'h04, 16'h00a5);
		$display("t_frame done");
	endtask
	////////////////////////////////////////
	initial begin
		{srst, pwm1, irq_req, in_stby, icc_low} = 5'h10;
		lin_rxd = 1'b1;
		status_set = '0;
		repeat (12) @(posedge clk);
		#1 srst = 1'b0;
		t_reset();
		t_bridge();
		t_ctrl();
		t_wd();
		t_status();
		t_frame();
		summarize();
	end
	// Hang guard
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		summarize();
	end
endmodule
`default_nettype wire
